// ==== j_counter.v ====
// five-bit binary up counter with complemented load and terminal count
`timescale 1ns/1ps
`include "tflag_map.vh"
module j_counter #(
   parameter WIDTH = `J_WIDTH
) (
   // clock and reset
   input wire core_clk,
   input wire rst,
   // control
   input wire load,
   input wire [WIDTH-1:0] load_bits,
   input wire inc,
   // state
   output wire [WIDTH-1:0] count,
   output wire j_terminal_count
);
   reg [WIDTH-1:0] j_ff;
   // load wins over increment
   always @(posedge core_clk) begin
      if (rst) begin
         j_ff <= {WIDTH{1'b0}};
      end else if (load) begin
         j_ff <= ~load_bits;
      end else if (inc) begin
         j_ff <= j_ff + {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end
   assign count = j_ff;
   assign j_terminal_count = (j_ff == {WIDTH{1'b1}});
endmodule

// ==== serial_adder.v ====
// one-bit serial full adder; operand gating is left to the instantiating module
`timescale 1ns/1ps
module serial_adder (
   // operands
   input wire a_in,
   input wire b_in,
   input wire carry_in,
   // result
   output wire sum,
   output wire carry_out
);
   // plain full adder
   assign sum = a_in ^ b_in ^ carry_in;
   assign carry_out = (a_in & b_in) | (a_in & carry_in) | (b_in & carry_in);
endmodule

// ==== test_flag_set_instructions.v ====
// Function
// - set op sets flag, keeps A
// - set op rotates A 24 times
// - bit-clear op loads J with ~I[4:0]
// - bit-clear op feeds inverted A0 to adder
// - bit-clear op holds carry flag set
// - J increments per shift; Z at 37
// - bit-clear sets flag if Z bit zero
// - nonzero op presets J to 7
// - nonzero op feeds A0 only, no carry
// - nonzero op sets flag on any one
// - nonzero op stops shifting at J=37
// - nonzero shift enable gated by terminal count
`timescale 1ns/1ps
`include "tflag_map.vh"
module test_flag_set_instructions #(
   parameter A_W = `A_WIDTH,
   parameter SHIFTS = `SHIFT_COUNT
) (
   // clock and reset
   input wire core_clk,
   input wire rst,
   // instruction and timing
   input wire start,
   input wire [1:0] op_sel,
   input wire [4:0] ir_low,
   // A register load port
   input wire a_load,
   input wire [A_W-1:0] a_load_data,
   // state out
   output wire [A_W-1:0] a_reg,
   output wire [4:0] j_count,
   output wire test_flag,
   output wire adder_carry_flag,
   output wire busy,
   output wire pc_advance
);
   localparam S_IDLE = 3'b001;
   localparam S_SHIFT = 3'b010;
   localparam S_DONE = 3'b100;

   reg [2:0] state_ff, nxt_state;
   reg [1:0] op_ff;
   reg [A_W-1:0] a_ff;
   reg [4:0] cnt_ff;
   reg flag_ff;
   reg carry_ff;
   wire j_terminal_count;
   wire [4:0] j_val;
   wire sum;
   wire carry_out;
   wire shifting = (state_ff == S_SHIFT);
   wire last_shift = (cnt_ff == SHIFTS - 1);
   wire test_flag_if_bit_clear_op = (op_ff == `OP_BIT_CLEAR);
   wire test_flag_if_nonzero_op = (op_ff == `OP_NONZERO);
   // nonzero op stops at terminal count, others use fixed 24
   wire a_shift_enable = shifting & (test_flag_if_nonzero_op ? ~j_terminal_count : 1'b1);
   // snz load ignores ir_low; the constant ~SNZ_PRESET is complemented back so the load yields 7
   // set op clears J so it ends at 24 after its free count
   wire [4:0] load_bits = (op_sel == `OP_NONZERO) ? ~`SNZ_PRESET :
                          (op_sel == `OP_SET) ? 5'h1F : ir_low;

   j_counter #(.WIDTH(5)) u_j (
      .core_clk(core_clk),
      .rst(rst),
      .load(start & (state_ff == S_IDLE)),
      .load_bits(load_bits),
      .inc(a_shift_enable),
      .count(j_val),
      .j_terminal_count(j_terminal_count)
   );

   // adder operand gating; b input stays off for all three ops
   serial_adder u_add (
      .a_in(test_flag_if_bit_clear_op ? ~a_ff[0] : a_ff[0]),
      .b_in(1'b0),
      .carry_in(carry_ff),
      .sum(sum),
      .carry_out(carry_out)
   );

   // sequencing
   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         S_IDLE: begin
            if (start && op_sel != `OP_NONE) begin
               nxt_state = S_SHIFT;
            end
         end
         S_SHIFT: begin
            if (test_flag_if_nonzero_op ? (j_terminal_count || last_shift) : last_shift) begin
               nxt_state = S_DONE;
            end
         end
         S_DONE: nxt_state = S_IDLE;
         default: nxt_state = S_IDLE;
      endcase
   end

   // datapath registers
   always @(posedge core_clk) begin
      if (rst) begin
         state_ff <= S_IDLE;
         op_ff <= `OP_NONE;
         a_ff <= {A_W{1'b0}};
         cnt_ff <= 5'h00;
         flag_ff <= 1'b0;
         carry_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         if (state_ff == S_IDLE && start) begin
            op_ff <= op_sel;
            cnt_ff <= 5'h00;
            // carry held set for bit-clear, cleared otherwise
            carry_ff <= (op_sel == `OP_BIT_CLEAR);
            if (op_sel == `OP_SET) begin
               flag_ff <= 1'b1;
            end
         end else if (state_ff == S_IDLE && a_load) begin
            a_ff <= a_load_data;
         end
         if (a_shift_enable) begin
            // circular shift: sum reenters at top, A restored after 24
            a_ff <= {sum, a_ff[A_W-1:1]};
            cnt_ff <= cnt_ff + 5'h01;
            // held carry is not updated by the sum; it is a forced level
            if (test_flag_if_bit_clear_op && j_terminal_count && !a_ff[0]) begin
               flag_ff <= 1'b1;
            end
            if (test_flag_if_nonzero_op && a_ff[0]) begin
               flag_ff <= 1'b1;
            end
         end
         if (state_ff == S_DONE) begin
            carry_ff <= 1'b0;
         end
      end
   end

   assign a_reg = a_ff;
   assign j_count = j_val;
   assign test_flag = flag_ff;
   assign adder_carry_flag = carry_ff;
   assign busy = (state_ff != S_IDLE);
   // one-cycle advance request; q and memory have no port here
   assign pc_advance = (state_ff == S_DONE);
endmodule

// ==== test_flag_set_instructions_tb.sv ====
// self-checking bench for the test-flag instructions
`timescale 1ns/1ps
`include "tflag_map.vh"
module test_flag_set_instructions_tb;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic a_load = 1'b0;
   logic [23:0] a_load_data = 24'h000000;
   wire start, test_flag, adder_carry_flag, busy, pc_advance;
   wire [1:0] op_sel;
   wire [4:0] ir_low, j_count;
   wire [23:0] a_reg;
   int failures = 0;
   int samples_checked = 0;
   always #2 core_clk = ~core_clk;
   tflag_ctl ctl (.core_clk(core_clk), .start(start), .op_sel(op_sel), .ir_low(ir_low));
   test_flag_set_instructions dut (.core_clk(core_clk), .rst(rst), .start(start),
      .op_sel(op_sel), .ir_low(ir_low), .a_load(a_load), .a_load_data(a_load_data),
      .a_reg(a_reg), .j_count(j_count), .test_flag(test_flag),
      .adder_carry_flag(adder_carry_flag), .busy(busy), .pc_advance(pc_advance));
   task check(input logic [23:0] seen, input logic [23:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task give_verdict;
      $display("checks %0d fails %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // fresh reset per op so the sticky flag starts low
   task run(input logic [1:0] op, input logic [4:0] z, input logic [23:0] a,
            input logic f, input logic [4:0] j);
      @(negedge core_clk);
      rst = 1'b1;
      @(negedge core_clk);
      rst = 1'b0;
      a_load = 1'b1;
      a_load_data = a;
      @(negedge core_clk);
      a_load = 1'b0;
      a_load_data = ~a;
      ctl.issue(op, z);
      repeat (24) @(negedge core_clk);
      check(pc_advance, 1'b1);
      @(negedge core_clk);
      check(test_flag, f);
      check(j_count, j);
      check(a_reg, a);
   endtask
   task t_set;
      run(`OP_SET, 5'h00, 24'hA5F00F, 1'b1, 5'h18);
      $display("set done");
   endtask
   // zero bit, one bit, top bit, index past 23
   task t_even;
      run(`OP_BIT_CLEAR, 5'h05, 24'h80001F, 1'b1, 5'h12);
      run(`OP_BIT_CLEAR, 5'h00, 24'h000001, 1'b0, 5'h17);
      run(`OP_BIT_CLEAR, 5'h17, 24'h7FFFFF, 1'b1, 5'h00);
      run(`OP_BIT_CLEAR, 5'h1E, 24'h000000, 1'b0, 5'h19);
      $display("bit-clear done");
   endtask
   task t_nz;
      run(`OP_NONZERO, 5'h00, 24'h000000, 1'b0, 5'h1F);
      run(`OP_NONZERO, 5'h1F, 24'h800000, 1'b1, 5'h1F);
      $display("nonzero done");
   endtask
   initial begin
      repeat (16) @(negedge core_clk);
      rst = 1'b0;
      t_set;
      t_even;
      t_nz;
      give_verdict;
   end
   // about four times the expected run
   initial begin
      #4000;
      failures++;
      give_verdict;
   end
endmodule

// ==== tflag_chk.sv ====
// port checks for the test-flag datapath
`timescale 1ns/1ps
module tflag_chk #(
   parameter A_W = 24
) (
   // clock and reset
   input wire core_clk,
   input wire rst,
   // instruction
   input wire start,
   input wire [1:0] op_sel,
   input wire [4:0] ir_low,
   // state
   input wire [A_W-1:0] a_reg,
   input wire [4:0] j_count,
   input wire test_flag,
   input wire adder_carry_flag,
   input wire busy,
   input wire pc_advance
);
   // refused strobes start no check
   wire go = start & ~busy & (op_sel != 2'h0);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (rst);
   // completion: one pulse, then low
   sequence s_done;
      pc_advance ##1 !pc_advance;
   endsequence
   a_set_flag: assert property (go && op_sel == 2'h1 |=> test_flag)
      else $error("set left flag low");
   a_a_kept: assert property (go |-> ##26 a_reg == $past(a_reg, 26))
      else $error("A changed");
   a_j_load: assert property (go && op_sel == 2'h2 |=> j_count == ~$past(ir_low))
      else $error("J load wrong");
   a_carry_held: assert property (go && op_sel == 2'h2 |=> adder_carry_flag[*8])
      else $error("carry not held");
   a_j_end: assert property (go && op_sel == 2'h2 |-> ##26 j_count == 5'h17 - $past(ir_low, 26))
      else $error("J end wrong");
   a_flag_kept: assert property (test_flag |=> test_flag)
      else $error("flag cleared");
   a_nz_preset: assert property (go && op_sel == 2'h3 |=> j_count == 5'h07)
      else $error("preset wrong");
   a_nz_stop: assert property (go && op_sel == 2'h3 |-> ##26 j_count == 5'h1F)
      else $error("J not at 37");
   a_pc_once: assert property (go |-> ##25 s_done)
      else $error("pc pulse wrong");
endmodule
bind test_flag_set_instructions tflag_chk #(.A_W(A_W)) chk (.core_clk(core_clk), .rst(rst),
   .start(start), .op_sel(op_sel), .ir_low(ir_low), .a_reg(a_reg), .j_count(j_count),
   .test_flag(test_flag), .adder_carry_flag(adder_carry_flag), .busy(busy),
   .pc_advance(pc_advance));

// ==== tflag_ctl.sv ====
// instruction register and state-4 timing model
`timescale 1ns/1ps
module tflag_ctl (
   // timing
   input wire core_clk,
   // instruction
   output logic start,
   output logic [1:0] op_sel,
   output logic [4:0] ir_low
);
   initial begin
      start = 1'b0;
      op_sel = 2'h0;
      ir_low = 5'h00;
   end
   // one strobe; op_sel clears and ir_low flips after so stale use shows
   task issue(input logic [1:0] op, input logic [4:0] z);
      @(negedge core_clk);
      start = 1'b1;
      op_sel = op;
      ir_low = (op == 2'h3) ? (z & 5'h18) : z;
      @(negedge core_clk);
      start = 1'b0;
      op_sel = 2'h0;
      ir_low = ~ir_low;
   endtask
endmodule

// ==== tflag_map.vh ====
// constants for the test-flag instruction datapath
`ifndef TFLAG_MAP_VH
`define TFLAG_MAP_VH
`define A_WIDTH 24
`define J_WIDTH 5
`define J_TERMINAL 5'h1F
`define SHIFT_COUNT 24
`define OP_SET 2'h1
`define OP_BIT_CLEAR 2'h2
`define OP_NONZERO 2'h3
`define OP_NONE 2'h0
`define SNZ_PRESET 5'h07
`endif
